// File: logic/watchdog_timeout_reset.sv
// Purpose: watchdog down counter with timeout interrupt and system reset
// Assumes: writes are one-cycle strobes synchronous to mclk
// Notes: control bits appear as plain ports, no register bus
//
// Contract
// - 32-bit counter counts down once enabled; reaching zero raises interrupt
// - enabling the counter also enables the timeout interrupt
// - after first timeout reload from the reload register and continue
// - second zero with interrupt pending and reset enabled asserts reset
// - clearing interrupt before second timeout reloads and resumes, no reset
// - reload write while running loads counter immediately
// - reload write keeps pending interrupt; only clear write clears it
// - enabling the interrupt preloads the counter from reload value
// - any write other than the key value to write-protect register locks the other registers
// - only the key value written to write-protect unlocks registers
// - setting interrupt enable starts watchdog and locks control
// - writing zero to the reload register raises the interrupt at once
// - a clear write while unlocked clears interrupt and reloads the counter
// - masked status is raw status AND interrupt enable
// - after interrupt enable is set, control writes are ignored
`timescale 1ns/1ps
`default_nettype none
module watchdog_timeout_reset
	import guard_pkg::*;
(
	input wire logic mclk,
	input wire logic rst,
	input wire sw_write_t sw_wr,
	output logic [31:0] interval_reload_register,
	output logic [31:0] count_value,
	output logic timeout_irq_enable,
	output logic system_reset_enable,
	output logic raw_irq,
	output logic masked_irq,
	output logic locked,
	output logic irq,
	output logic system_reset
);
	guard_state_t state;
	guard_state_t next_state;

	function automatic logic [31:0] dec1(input logic [31:0] v);
		dec1 = v - 32'h0000_0001;
	endfunction : dec1

	// locked registers drop every write except the unlock key attempt
	wire logic open_wr = !locked;
	wire logic reload_hit = sw_wr.reload_wr && open_wr;
	wire logic clear_hit = sw_wr.clear_wr && open_wr;
	// control ignored for good once the interrupt enable is set
	wire logic ctl_hit = sw_wr.ctl_wr && open_wr
		&& !timeout_irq_enable;
	wire logic irq_on = ctl_hit && sw_wr.data[CTL_IRQ_EN_BIT];
	wire logic running = timeout_irq_enable;
	wire logic at_zero = running && count_value == COUNT_ZERO;
	// zero load fires at once rather than waiting a full wrap
	wire logic zero_load = reload_hit && sw_wr.data == COUNT_ZERO;
	wire logic timeout = at_zero && !reload_hit && !clear_hit;
	wire logic second_hit = timeout && raw_irq;
	wire logic set_irq = (timeout && !raw_irq) || zero_load;
	wire logic fire_reset = second_hit && system_reset_enable;
	wire logic next_raw = set_irq || (raw_irq && !clear_hit);
	wire logic [31:0] next_count =
		reload_hit ? sw_wr.data :
		(clear_hit || irq_on || timeout) ? interval_reload_register :
		running ? dec1(count_value) : count_value;

	always_comb begin
		next_state = state;
		case (state)
			ST_IDLE: if (irq_on) next_state = next_raw ? ST_PENDING : ST_ARMED;
			ST_ARMED: if (set_irq) next_state = ST_PENDING;
			ST_PENDING: begin
				if (fire_reset) next_state = ST_FIRED;
				else if (clear_hit && !zero_load) next_state = ST_ARMED;
			end
			ST_FIRED: next_state = ST_FIRED;
			default: next_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			state <= ST_IDLE;
			interval_reload_register <= RELOAD_RESET;
			count_value <= RELOAD_RESET;
			{system_reset_enable, timeout_irq_enable} <= CTL_RESET;
			locked <= 1'b0;
			raw_irq <= 1'b0;
			masked_irq <= 1'b0;
			irq <= 1'b0;
			system_reset <= 1'b0;
		end else begin
			state <= next_state;
			count_value <= next_count;
			if (reload_hit)
				interval_reload_register <= sw_wr.data;
			if (ctl_hit) begin
				system_reset_enable <= sw_wr.data[CTL_RESET_EN_BIT];
				timeout_irq_enable <= sw_wr.data[CTL_IRQ_EN_BIT];
			end
			if (sw_wr.protect_wr)
				locked <= sw_wr.data != UNLOCK_KEY;
			// set wins over a clear landing in the same cycle
			raw_irq <= next_raw;
			masked_irq <= next_raw && (timeout_irq_enable || irq_on);
			irq <= next_raw && (timeout_irq_enable || irq_on);
			system_reset <= system_reset || fire_reset;
		end
	end

	property p_mask;
		@(posedge mclk) disable iff (rst)
			masked_irq == (raw_irq && timeout_irq_enable);
	endproperty
	chk_masked_status: assert property (p_mask)
		else $error("masked status differs from raw and enable");

	chk_reset_holds: assert property (
		@(posedge mclk) disable iff (rst)
		system_reset |=> system_reset)
		else $error("system reset dropped");

	chk_reset_cause: assert property (
		@(posedge mclk) disable iff (rst)
		$rose(system_reset) |-> $past(raw_irq) && system_reset_enable
		&& $past(count_value) == COUNT_ZERO)
		else $error("reset without pending second timeout");

	chk_first_timeout: assert property (
		@(posedge mclk) disable iff (rst)
		at_zero && !raw_irq && !reload_hit && !clear_hit |=> raw_irq
		&& count_value == interval_reload_register)
		else $error("first timeout missed or no reload");

	chk_reload_write: assert property (
		@(posedge mclk) disable iff (rst)
		reload_hit |=> count_value == $past(sw_wr.data)
		&& interval_reload_register == $past(sw_wr.data))
		else $error("reload write not applied");

	chk_reload_keeps_irq: assert property (
		@(posedge mclk) disable iff (rst)
		raw_irq && sw_wr.reload_wr && !sw_wr.clear_wr |=> raw_irq)
		else $error("reload write cleared interrupt");

	chk_zero_load: assert property (
		@(posedge mclk) disable iff (rst)
		reload_hit && sw_wr.data == COUNT_ZERO |=> raw_irq)
		else $error("zero load did not raise interrupt");

	sequence s_clear_taken;
		clear_hit && !at_zero && !zero_load;
	endsequence
	chk_clear_reload: assert property (
		@(posedge mclk) disable iff (rst)
		s_clear_taken |=> !raw_irq
		&& count_value == interval_reload_register)
		else $error("clear did not reload and clear");

	chk_ctl_locked: assert property (
		@(posedge mclk) disable iff (rst)
		timeout_irq_enable |=> timeout_irq_enable
		&& $stable(system_reset_enable))
		else $error("control changed after enable");

	chk_lock_write: assert property (
		@(posedge mclk) disable iff (rst)
		sw_wr.protect_wr |=> locked == ($past(sw_wr.data) != UNLOCK_KEY))
		else $error("lock state wrong after protect write");

	chk_count_down: assert property (
		@(posedge mclk) disable iff (rst)
		running && !at_zero && !sw_wr.reload_wr && !sw_wr.clear_wr
		|=> count_value == $past(count_value) - 32'h0000_0001)
		else $error("counter did not decrement");

	chk_enable_preload: assert property (
		@(posedge mclk) disable iff (rst)
		irq_on && !reload_hit |=> timeout_irq_enable
		&& count_value == interval_reload_register)
		else $error("enable did not preload");

	// the state register mirrors the flags so a stray state is caught
	property p_fired;
		@(posedge mclk) disable iff (rst)
			system_reset == (state == ST_FIRED);
	endproperty
	chk_fired_state: assert property (p_fired)
		else $error("fired state and reset output disagree");

	property p_idle;
		@(posedge mclk) disable iff (rst)
			(state == ST_IDLE) == !timeout_irq_enable;
	endproperty
	chk_idle_quiet: assert property (p_idle)
		else $error("idle state and enable disagree");

	property p_pending;
		@(posedge mclk) disable iff (rst)
			state == ST_PENDING |-> raw_irq;
	endproperty
	chk_pending_raw: assert property (p_pending)
		else $error("pending state without raw interrupt");

	property p_armed;
		@(posedge mclk) disable iff (rst)
			state == ST_ARMED |-> !raw_irq;
	endproperty
	chk_armed_clear: assert property (p_armed)
		else $error("armed state with raw interrupt set");

	property p_locked_reload;
		@(posedge mclk) disable iff (rst)
			locked && sw_wr.reload_wr |=> $stable(interval_reload_register);
	endproperty
	chk_locked_reload: assert property (p_locked_reload)
		else $error("reload changed while locked");

	property p_locked_clear;
		@(posedge mclk) disable iff (rst)
			locked && raw_irq && sw_wr.clear_wr |=> raw_irq;
	endproperty
	chk_locked_clear: assert property (p_locked_clear)
		else $error("clear taken while locked");

	property p_locked_ctl;
		@(posedge mclk) disable iff (rst)
			locked && sw_wr.ctl_wr |=> $stable({system_reset_enable,
			timeout_irq_enable});
	endproperty
	chk_locked_ctl: assert property (p_locked_ctl)
		else $error("control changed while locked");

	property p_mirror;
		@(posedge mclk) disable iff (rst)
			irq == masked_irq;
	endproperty
	chk_irq_mirror: assert property (p_mirror)
		else $error("interrupt output differs from masked status");

	sequence s_second_zero;
		at_zero && raw_irq && system_reset_enable && !reload_hit && !clear_hit;
	endsequence
	property p_second;
		@(posedge mclk) disable iff (rst)
			s_second_zero |=> system_reset;
	endproperty
	chk_second_reset: assert property (p_second)
		else $error("second timeout did not reset");

	property p_gated;
		@(posedge mclk) disable iff (rst)
			!system_reset_enable && !system_reset |=> !system_reset;
	endproperty
	chk_reset_gated: assert property (p_gated)
		else $error("reset asserted while disabled");

	property p_timeout_reload;
		@(posedge mclk) disable iff (rst)
			at_zero && !reload_hit && !clear_hit
			|=> count_value == interval_reload_register;
	endproperty
	chk_timeout_reload: assert property (p_timeout_reload)
		else $error("counter not reloaded after timeout");

	property p_clear_safe;
		@(posedge mclk) disable iff (rst)
			clear_hit |=> system_reset == $past(system_reset);
	endproperty
	chk_clear_no_reset: assert property (p_clear_safe)
		else $error("reset asserted despite clear");

	property p_stops;
		@(posedge mclk) disable iff (rst)
			!running && !reload_hit && !clear_hit && !irq_on
			|=> $stable(count_value);
	endproperty
	chk_count_stops: assert property (p_stops)
		else $error("counter moved while disabled");

	property p_lock_hold;
		@(posedge mclk) disable iff (rst)
			!sw_wr.protect_wr |=> $stable(locked);
	endproperty
	chk_lock_hold: assert property (p_lock_hold)
		else $error("lock changed without protect write");

	// a zero interval keeps landing on zero, so the flag stays raised
	sequence s_zero_run;
		at_zero && interval_reload_register == COUNT_ZERO
		&& !reload_hit && !clear_hit;
	endsequence
	property p_zero_run;
		@(posedge mclk) disable iff (rst)
			s_zero_run |=> count_value == COUNT_ZERO && raw_irq;
	endproperty
	chk_zero_repeat: assert property (p_zero_run)
		else $error("zero interval did not hold interrupt");

	property p_raw_source;
		@(posedge mclk) disable iff (rst)
			!raw_irq && !set_irq |=> !raw_irq;
	endproperty
	chk_raw_source: assert property (p_raw_source)
		else $error("raw interrupt set without cause");

	property p_ctl_write;
		@(posedge mclk) disable iff (rst)
			ctl_hit |=> system_reset_enable
			== $past(sw_wr.data[CTL_RESET_EN_BIT]);
	endproperty
	chk_ctl_reset_en: assert property (p_ctl_write)
		else $error("reset enable not taken from control write");
endmodule : watchdog_timeout_reset
`default_nettype wire

// File: logic/guard_pkg.sv
// Purpose: constants and types shared by the timeout guard
// Assumes: one clock, 32-bit software writes
// Notes: write strobes arrive as packed structs
package guard_pkg;
	localparam logic [31:0] RELOAD_RESET = 32'hffff_ffff;
	localparam logic [31:0] UNLOCK_KEY = 32'h1acc_e551;
	localparam logic [31:0] COUNT_ZERO = 32'h0000_0000;
	localparam int CTL_RESET_EN_BIT = 1;
	localparam int CTL_IRQ_EN_BIT = 0;
	localparam logic [1:0] CTL_RESET = 2'h0;

	typedef struct packed {
		logic reload_wr;
		logic clear_wr;
		logic ctl_wr;
		logic protect_wr;
		logic [31:0] data;
	} sw_write_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_ARMED = 2'b01,
		ST_PENDING = 2'b10,
		ST_FIRED = 2'b11
	} guard_state_t;
endpackage : guard_pkg

// File: verif/irq_reset_sink.sv
// Purpose: interrupt controller and system reset catcher for the guard
// Assumes: irq and reset request are levels in the mclk domain
// Notes: counts interrupt rising edges, latches any reset request
`timescale 1ns/1ps
`default_nettype none
module irq_reset_sink (
	input wire logic mclk,
	input wire logic rst,
	input wire logic irq,
	input wire logic system_reset,
	output logic [7:0] irq_edges,
	output logic reset_seen
);
	logic irq_d;
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			irq_d <= 1'b0;
			irq_edges <= 8'h00;
			reset_seen <= 1'b0;
		end else begin
			irq_d <= irq;
			irq_edges <= irq_edges + {7'h00, irq && !irq_d};
			reset_seen <= reset_seen | system_reset;
		end
	end
endmodule : irq_reset_sink
`default_nettype wire

// File: verif/watchdog_timeout_reset_test.sv
// Purpose: self-checking bench for the timeout guard
// Assumes: inputs change at the falling edge
// Notes: control locks once enabled, so one enable per run
`timescale 1ns/1ps
`default_nettype none
module watchdog_timeout_reset_test;
	import guard_pkg::*;
	localparam logic [3:0] RLD = 4'h8, CLR = 4'h4, CTL = 4'h2, PRT = 4'h1;
	logic mclk, rst, ien, ren, raw, masked, locked, irq, sres, seen;
	sw_write_t sw_wr;
	logic [31:0] reload, count;
	logic [7:0] edges;
	int failures, checked;
	watchdog_timeout_reset i_watchdog_timeout_reset(.mclk(mclk), .rst(rst),
		.sw_wr(sw_wr), .interval_reload_register(reload), .count_value(count),
		.timeout_irq_enable(ien), .system_reset_enable(ren), .raw_irq(raw),
		.masked_irq(masked), .locked(locked), .irq(irq), .system_reset(sres));
	irq_reset_sink i_irq_reset_sink(.mclk(mclk), .rst(rst), .irq(irq),
		.system_reset(sres), .irq_edges(edges), .reset_seen(seen));
	// the clock gate is taken as already open
	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end
	task automatic finish_test();
		if (failures == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : finish_test
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic wr(input logic [3:0] s, input logic [31:0] d);
		@(negedge mclk);
		sw_wr = {s, d};
		@(negedge mclk);
		sw_wr = '0;
	endtask : wr
	task automatic wait_hi(input bit on_reset);
		for (int i = 0; i < 64; i++) begin
			if ((on_reset ? sres : raw) === 1'b1)
				return;
			@(negedge mclk);
		end
		failures++;
		finish_test();
	endtask : wait_hi
	initial begin
		rst = 1'b1;
		sw_wr = '0;
		repeat (4) @(negedge mclk);
		rst = 1'b0;
		chk("count", RELOAD_RESET, count);
		chk("flags", 32'h0, {25'h0, ien, ren, raw, masked, locked, irq, sres});
		wr(PRT, 32'h0000_0000);
		wr(RLD, 32'h0000_0003);
		wr(CTL, 32'h0000_0003);
		chk("reload", RELOAD_RESET, reload);
		chk("enables", 32'h0, {30'h0, ien, ren});
		wr(PRT, 32'h1acc_e550);
		chk("locked", 32'h1, {31'h0, locked});
		wr(PRT, UNLOCK_KEY);
		chk("locked", 32'h0, {31'h0, locked});
		wr(RLD, 32'h0000_0005);
		wr(CTL, 32'h0000_0003);
		chk("enables", 32'h3, {30'h0, ien, ren});
		chk("count", 32'h0000_0005, count);
		@(negedge mclk);
		chk("count", 32'h0000_0004, count);
		wait_hi(1'b0);
		chk("count", 32'h0000_0005, count);
		chk("irq", 32'h3, {30'h0, masked, irq});
		wr(CTL, 32'h0000_0000);
		chk("enables", 32'h3, {30'h0, ien, ren});
		wr(RLD, 32'h0000_0008);
		chk("count", 32'h0000_0008, count);
		chk("raw", 32'h1, {31'h0, raw});
		wr(CLR, 32'h0000_0000);
		chk("raw count", 32'h0000_0008, {raw, count[30:0]});
		wait_hi(1'b0);
		chk("reset count", 32'h0000_0008, {sres, count[30:0]});
		wr(CLR, 32'h0000_0000);
		wr(RLD, 32'h0000_0000);
		chk("raw", 32'h1, {31'h0, raw});
		wait_hi(1'b1);
		repeat (5) @(negedge mclk);
		chk("reset", 32'h1, {31'h0, sres});
		chk("sink", 32'h0000_0103, {23'h0, seen, edges});
		finish_test();
	end
endmodule : watchdog_timeout_reset_test
`default_nettype wire
